// [rtl/npcc_pkg.sv]
// constants and types shared by the node packet comms controller
`default_nettype none
package npcc_pkg;
  // ********************************
  // address decode
  // ********************************
  localparam logic [3:0] NPCC_BASE_BUF = 4'h2; // haddr[31:28], buffered
  localparam logic [3:0] NPCC_BASE_UNBUF = 4'h1; // haddr[31:28], unbuffered
  localparam logic [4:0] NPCC_OFF_TX_CONTROL = 5'h00;
  localparam logic [4:0] NPCC_OFF_TX_DATA = 5'h04;
  localparam logic [4:0] NPCC_OFF_TX_KEY = 5'h08;
  localparam logic [4:0] NPCC_OFF_RX_STATUS = 5'h0C;
  localparam logic [4:0] NPCC_OFF_RX_DATA = 5'h10;
  localparam logic [4:0] NPCC_OFF_RX_KEY = 5'h14;
  localparam logic [4:0] NPCC_OFF_SRC_ROUTE = 5'h18;
  localparam logic [4:0] NPCC_OFF_TEST = 5'h1C;
  // wait cycles (hreadyout low) per access
  localparam logic [1:0] NPCC_WAIT_BUF = 2'h1;
  localparam logic [1:0] NPCC_WAIT_UNBUF = 2'h2;
  // ********************************
  // register fields
  // ********************************
  localparam int NPCC_CTRL_LSB = 16; // control byte in tx_control/rx_status
  localparam int NPCC_TX_EMPTY = 31;
  localparam int NPCC_TX_FULL = 30;
  localparam int NPCC_TX_OVR = 29;
  localparam int NPCC_TX_NFULL = 28;
  localparam int NPCC_RX_RCVD = 31;
  localparam int NPCC_RX_PAR = 30;
  localparam int NPCC_RX_FRM = 29;
  localparam int NPCC_RX_OK = 28;
  localparam int NPCC_ROUTE_LSB = 24; // route in rx_status and SOURCE_ADDRESS_ROUTE
  localparam logic [2:0] NPCC_ROUTE_RST = 3'h7; // router stamps packets
  localparam logic [7:0] NPCC_CTRL_RST = 8'h00;
  // ********************************
  // control byte
  // ********************************
  localparam logic [1:0] NPCC_PT_MC = 2'h0;
  localparam logic [1:0] NPCC_PT_P2P = 2'h1;
  localparam logic [1:0] NPCC_PT_NN = 2'h2;
  localparam logic [1:0] NPCC_PT_FR = 2'h3;
  localparam int NPCC_CB_PAY = 1;
  localparam int NPCC_CB_PAR = 0;
  // transmit sequencer, one-hot
  typedef enum logic [3:0] {
    NPCC_S_IDLE = 4'h1,
    NPCC_S_CTRL = 4'h2,
    NPCC_S_KEY = 4'h4,
    NPCC_S_DATA = 4'h8
  } npcc_tx_st_t;
endpackage
`default_nettype wire

// [rtl/npcc_top.sv]
// node packet comms controller: AHB-Lite registers, packet launch, receive
//
// How it works
// R1 - packets are control+key, plus optional payload word
// R2 - control bits 7:6 give packet type
// R3 - multicast: control, routing key, optional payload
// R4 - point-to-point: control, source id, destination id
// R5 - neighbour: control, address/operation, optional payload
// R6 - fixed-route: control, payload, optional extension word
// R7 - bit 0 makes whole packet odd parity
// R8 - bit 1 set when payload word carried
// R9 - time stamp is launch phase, gray sequence
// R10 - route 111: router stamps, else use tx_control
// R11 - router diverts packets two phases old
// R12 - point-to-point bits 5:4 carry sequence code
// R13 - multicast/fixed-route bits 5:4 are emergency routing
// R14 - neighbour route bits taken from control setting
// R15 - neighbour bit 5 selects normal or peek/poke
// R16 - peek is neighbour packet, aligned address, no payload
// R17 - read answer: normal packet, flagged echoed address
// R18 - poke carries payload; answer reports error status
// R19 - two bases: buffered and unbuffered write timing
// R20 - payload only when data written before key
// R21 - each key write launches exactly one packet (here a key write while the sequencer is busy launches none and sets overrun)
// R22 - destination from key 15:0, sequence 17:16
// R23 - launch replaces parity and sequence fields
// R24 - beats go control, key fields, then payload
`default_nettype none
module npcc_top
  import npcc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic pkt_valid,
  input wire logic pkt_ready,
  output logic [31:0] pkt_word,
  output logic pkt_first,
  output logic pkt_last,
  output logic [2:0] pkt_route,
  input wire logic rx_pkt_valid,
  input wire logic [7:0] rx_pkt_ctrl,
  input wire logic [31:0] rx_pkt_key,
  input wire logic [31:0] rx_pkt_data,
  input wire logic [2:0] rx_pkt_route,
  input wire logic rx_pkt_frame_err
);

  // ********************************
  // functions
  // ********************************
  // true when the whole packet has odd parity
  function automatic logic npcc_odd(input logic [7:0] c,
                                    input logic [31:0] k,
                                    input logic [31:0] d);
    npcc_odd = ^{c, k, (c[NPCC_CB_PAY] ? d : 32'h0)};
  endfunction

  // ********************************
  // bus group
  // ********************************
  logic busy_r, busy_nxt; // data phase in progress
  logic wr_r, wr_nxt; // captured hwrite
  logic map_r, map_nxt; // address hit one of the bases
  logic [4:0] off_r, off_nxt; // captured word offset
  logic [1:0] wcnt_r, wcnt_nxt; // wait cycles left
  logic hready_r, hready_nxt;
  logic hresp_r, hresp_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic [7:0] tcb_r, tcb_nxt; // tx control byte from software
  logic [31:0] tdr_r, tdr_nxt; // tx payload word
  logic tdw_r, tdw_nxt; // payload written since last key write
  logic [2:0] sroute_r, sroute_nxt; // fake route for router
  logic [15:0] srcid_r, srcid_nxt; // own chip id
  logic [31:0] tst_r, tst_nxt; // test scratch word
  // one-cycle strobes to the other groups
  logic do_acc, launch, wr_tcr, wr_rsr, rd_rkr;
  // state shown by other groups
  npcc_tx_st_t st_r, st_nxt;
  logic full_r, full_nxt, ovr_r, ovr_nxt;
  logic rcv_r, rcv_nxt, perr_r, perr_nxt, ferr_r, ferr_nxt, ok_r, ok_nxt;
  logic [2:0] rroute_r, rroute_nxt;
  logic [7:0] rcb_r, rcb_nxt;
  logic [3:0] rtype_r, rtype_nxt; // F N P M
  logic [31:0] rdr_r, rdr_nxt, rkr_r, rkr_nxt;

  // address phase, wait count, register writes and read mux
  always_comb begin
    logic [3:0] base;
    logic idle;
    base = haddr[31:28];
    idle = (st_r == NPCC_S_IDLE);
    busy_nxt = busy_r;
    wr_nxt = wr_r;
    map_nxt = map_r;
    off_nxt = off_r;
    wcnt_nxt = wcnt_r;
    hready_nxt = hready_r;
    hresp_nxt = 1'b0; // always OKAY
    hrdata_nxt = hrdata_r;
    tcb_nxt = tcb_r;
    tdr_nxt = tdr_r;
    tdw_nxt = tdw_r;
    sroute_nxt = sroute_r;
    srcid_nxt = srcid_r;
    tst_nxt = tst_r;
    do_acc = 1'b0;
    launch = 1'b0;
    wr_tcr = 1'b0;
    wr_rsr = 1'b0;
    rd_rkr = 1'b0;
    if (hsel && htrans[1] && hready && !busy_r) begin
      // new transfer: always at least one wait so hrdata is a flop
      busy_nxt = 1'b1;
      wr_nxt = hwrite;
      off_nxt = {haddr[4:2], 2'b00};
      map_nxt = (base == NPCC_BASE_BUF) || (base == NPCC_BASE_UNBUF);
      hready_nxt = 1'b0;
      // unbuffered writes stall one extra cycle
      wcnt_nxt = (hwrite && base == NPCC_BASE_UNBUF) ?
                 NPCC_WAIT_UNBUF : NPCC_WAIT_BUF; // R19
    end else if (busy_r) begin
      if (wcnt_r == 2'h1) begin
        do_acc = 1'b1;
        busy_nxt = 1'b0;
        hready_nxt = 1'b1;
      end else begin
        wcnt_nxt = wcnt_r - 2'h1;
      end
    end
    if (do_acc && wr_r && map_r) begin
      case (off_r)
        NPCC_OFF_TX_CONTROL: begin
          tcb_nxt = hwdata[NPCC_CTRL_LSB +: 8];
          wr_tcr = 1'b1;
        end
        NPCC_OFF_TX_DATA: begin
          tdr_nxt = hwdata;
          tdw_nxt = 1'b1; // R20
        end
        NPCC_OFF_TX_KEY: begin
          launch = 1'b1; // R21
          tdw_nxt = 1'b0; // payload consumed by this key write
        end
        NPCC_OFF_RX_STATUS: wr_rsr = 1'b1;
        NPCC_OFF_SRC_ROUTE: begin
          sroute_nxt = hwdata[NPCC_ROUTE_LSB +: 3];
          srcid_nxt = hwdata[15:0];
        end
        NPCC_OFF_TEST: tst_nxt = hwdata;
        default: ; // read-only words (rx data and rx key) ignore writes
      endcase
    end
    if (do_acc && !wr_r) begin
      hrdata_nxt = 32'h0; // unmapped and write-only words read zero
      if (map_r) begin
        case (off_r)
          NPCC_OFF_TX_CONTROL: begin
            hrdata_nxt[NPCC_TX_EMPTY] = idle;
            hrdata_nxt[NPCC_TX_FULL] = full_r;
            hrdata_nxt[NPCC_TX_OVR] = ovr_r;
            hrdata_nxt[NPCC_TX_NFULL] = idle;
            hrdata_nxt[NPCC_CTRL_LSB +: 8] = tcb_r;
          end
          NPCC_OFF_RX_STATUS: begin
            hrdata_nxt[NPCC_RX_RCVD] = rcv_r;
            hrdata_nxt[NPCC_RX_PAR] = perr_r;
            hrdata_nxt[NPCC_RX_FRM] = ferr_r;
            hrdata_nxt[NPCC_RX_OK] = ok_r;
            hrdata_nxt[NPCC_ROUTE_LSB +: 3] = rroute_r;
            hrdata_nxt[NPCC_CTRL_LSB +: 8] = rcb_r;
            hrdata_nxt[3:0] = rtype_r;
          end
          NPCC_OFF_RX_DATA: hrdata_nxt = rdr_r;
          NPCC_OFF_RX_KEY: begin
            hrdata_nxt = rkr_r;
            rd_rkr = 1'b1; // read-sensitive
          end
          NPCC_OFF_SRC_ROUTE: begin
            hrdata_nxt[NPCC_ROUTE_LSB +: 3] = sroute_r;
            hrdata_nxt[15:0] = srcid_r;
          end
          NPCC_OFF_TEST: hrdata_nxt = tst_r;
          default: hrdata_nxt = 32'h0;
        endcase
      end
    end
  end

  // bus group registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_r <= 1'b0;
      wr_r <= 1'b0;
      map_r <= 1'b0;
      off_r <= 5'h00;
      wcnt_r <= 2'h0;
      hready_r <= 1'b1;
      hresp_r <= 1'b0;
      hrdata_r <= 32'h0;
      tcb_r <= NPCC_CTRL_RST;
      tdr_r <= 32'h0;
      tdw_r <= 1'b0;
      sroute_r <= NPCC_ROUTE_RST;
      srcid_r <= 16'h0;
      tst_r <= 32'h0;
    end else begin
      busy_r <= busy_nxt;
      wr_r <= wr_nxt;
      map_r <= map_nxt;
      off_r <= off_nxt;
      wcnt_r <= wcnt_nxt;
      hready_r <= hready_nxt;
      hresp_r <= hresp_nxt;
      hrdata_r <= hrdata_nxt;
      tcb_r <= tcb_nxt;
      tdr_r <= tdr_nxt;
      tdw_r <= tdw_nxt;
      sroute_r <= sroute_nxt;
      srcid_r <= srcid_nxt;
      tst_r <= tst_nxt;
    end
  end

  // ********************************
  // transmit group
  // ********************************
  logic [7:0] cq_r, cq_nxt; // launched control byte
  logic [31:0] kq_r, kq_nxt; // key / id / first payload beat
  logic [31:0] pq_r, pq_nxt; // optional payload beat
  logic pv_r, pv_nxt, pf_r, pf_nxt, pl_r, pl_nxt;
  logic [31:0] pw_r, pw_nxt;
  logic [2:0] prt_r, prt_nxt;

  // single packet buffer: a key write while busy is lost as overrun
  always_comb begin
    logic [7:0] c;
    logic [31:0] k;
    st_nxt = st_r;
    cq_nxt = cq_r;
    kq_nxt = kq_r;
    pq_nxt = pq_r;
    full_nxt = full_r;
    ovr_nxt = ovr_r;
    pv_nxt = pv_r;
    pf_nxt = pf_r;
    pl_nxt = pl_r;
    pw_nxt = pw_r;
    prt_nxt = sroute_r; // router sees sroute_r; at its reset value 111 the router stamps itself
    // sticky flags cleared by writing zero; a set below wins
    if (wr_tcr && !hwdata[NPCC_TX_FULL]) full_nxt = 1'b0;
    if (wr_tcr && !hwdata[NPCC_TX_OVR]) ovr_nxt = 1'b0;
    // stamp, route, subtype and emergency bits pass as written
    c = tcb_r; // R9 R10 R13 R14 R15 R16
    c[NPCC_CB_PAY] = tdw_r; // R8 R20
    k = hwdata; // R3 R5 R6
    if (tcb_r[7:6] == NPCC_PT_P2P) begin // R2
      c[5:4] = hwdata[17:16]; // R12 R22 R23
      k = {srcid_r, hwdata[15:0]}; // R4 R22
    end
    c[NPCC_CB_PAR] = 1'b0;
    c[NPCC_CB_PAR] = ~npcc_odd(c, k, tdr_r); // R7 R23
    case (st_r)
      NPCC_S_IDLE: begin
        if (launch) begin
          cq_nxt = c;
          kq_nxt = k;
          pq_nxt = tdr_r;
          full_nxt = 1'b1;
          st_nxt = NPCC_S_CTRL;
          pv_nxt = 1'b1;
          pf_nxt = 1'b1;
          pl_nxt = 1'b0;
          pw_nxt = {24'h0, c}; // R24
        end
      end
      NPCC_S_CTRL: begin
        if (launch) ovr_nxt = 1'b1;
        if (pkt_ready) begin
          st_nxt = NPCC_S_KEY;
          pf_nxt = 1'b0;
          pw_nxt = kq_r; // R24
          pl_nxt = !cq_r[NPCC_CB_PAY]; // R1
        end
      end
      NPCC_S_KEY: begin
        if (launch) ovr_nxt = 1'b1;
        if (pkt_ready) begin
          if (cq_r[NPCC_CB_PAY]) begin
            st_nxt = NPCC_S_DATA;
            pw_nxt = pq_r; // R1 R24
            pl_nxt = 1'b1;
          end else begin
            st_nxt = NPCC_S_IDLE;
            pv_nxt = 1'b0;
            pl_nxt = 1'b0;
          end
        end
      end
      NPCC_S_DATA: begin
        if (launch) ovr_nxt = 1'b1;
        if (pkt_ready) begin
          st_nxt = NPCC_S_IDLE;
          pv_nxt = 1'b0;
          pl_nxt = 1'b0;
        end
      end
      default: begin
        st_nxt = NPCC_S_IDLE;
        pv_nxt = 1'b0;
      end
    endcase
  end

  // transmit group registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= NPCC_S_IDLE;
      cq_r <= 8'h00;
      kq_r <= 32'h0;
      pq_r <= 32'h0;
      full_r <= 1'b0;
      ovr_r <= 1'b0;
      pv_r <= 1'b0;
      pf_r <= 1'b0;
      pl_r <= 1'b0;
      pw_r <= 32'h0;
      prt_r <= NPCC_ROUTE_RST;
    end else begin
      st_r <= st_nxt;
      cq_r <= cq_nxt;
      kq_r <= kq_nxt;
      pq_r <= pq_nxt;
      full_r <= full_nxt;
      ovr_r <= ovr_nxt;
      pv_r <= pv_nxt;
      pf_r <= pf_nxt;
      pl_r <= pl_nxt;
      pw_r <= pw_nxt;
      prt_r <= prt_nxt;
    end
  end

  // ********************************
  // receive group
  // ********************************
  // latch each arriving packet; peek/poke answers land here as NN
  always_comb begin
    logic good;
    good = npcc_odd(rx_pkt_ctrl, rx_pkt_key, rx_pkt_data); // R7
    rcv_nxt = rcv_r;
    perr_nxt = perr_r;
    ferr_nxt = ferr_r;
    ok_nxt = ok_r;
    rroute_nxt = rroute_r;
    rcb_nxt = rcb_r;
    rtype_nxt = rtype_r;
    rdr_nxt = rdr_r;
    rkr_nxt = rkr_r;
    if (rd_rkr) rcv_nxt = 1'b0;
    if (wr_rsr && !hwdata[NPCC_RX_PAR]) perr_nxt = 1'b0;
    if (wr_rsr && !hwdata[NPCC_RX_FRM]) ferr_nxt = 1'b0;
    if (rx_pkt_valid) begin
      // arrival after the clears so a same-cycle event is kept
      rcv_nxt = 1'b1;
      if (!good) perr_nxt = 1'b1;
      if (rx_pkt_frame_err) ferr_nxt = 1'b1;
      ok_nxt = good && !rx_pkt_frame_err;
      rroute_nxt = rx_pkt_route;
      rcb_nxt = rx_pkt_ctrl;
      rtype_nxt = 4'h0;
      if (good && !rx_pkt_frame_err) begin
        rtype_nxt[rx_pkt_ctrl[7:6]] = 1'b1; // R2 R17
      end
      rkr_nxt = rx_pkt_key;
      if (rx_pkt_ctrl[NPCC_CB_PAY]) rdr_nxt = rx_pkt_data; // R8 R17 R18
    end
  end

  // receive group registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rcv_r <= 1'b0;
      perr_r <= 1'b0;
      ferr_r <= 1'b0;
      ok_r <= 1'b0;
      rroute_r <= 3'h0;
      rcb_r <= 8'h00;
      rtype_r <= 4'h0;
      rdr_r <= 32'h0;
      rkr_r <= 32'h0;
    end else begin
      rcv_r <= rcv_nxt;
      perr_r <= perr_nxt;
      ferr_r <= ferr_nxt;
      ok_r <= ok_nxt;
      rroute_r <= rroute_nxt;
      rcb_r <= rcb_nxt;
      rtype_r <= rtype_nxt;
      rdr_r <= rdr_nxt;
      rkr_r <= rkr_nxt;
    end
  end

  // ports straight from flops
  assign hreadyout = hready_r;
  assign hresp = hresp_r;
  assign hrdata = hrdata_r;
  assign pkt_valid = pv_r;
  assign pkt_word = pw_r;
  assign pkt_first = pf_r;
  assign pkt_last = pl_r;
  assign pkt_route = prt_r;

  // ********************************
  // assertions
  // ********************************
  default clocking npcc_cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic go;
  assign go = launch && (st_r == NPCC_S_IDLE);

  sequence s_ctrl_beat;
    pv_r && pf_r && pkt_ready;
  endsequence
  sequence s_key_beat;
    pv_r && !pf_r && (st_r == NPCC_S_KEY);
  endsequence

  AST_NOT_SHORT: assert property (pv_r && pf_r |-> !pl_r) // R1
    else $error("control beat marked last");
  AST_TYPE_KEPT: assert property (go |=> cq_r[7:6] == $past(tcb_r[7:6])) // R2
    else $error("packet type not taken from tx_control");
  AST_P2P_IDS: assert property (go && tcb_r[7:6] == NPCC_PT_P2P |=>
      kq_r == {$past(srcid_r), $past(hwdata[15:0])}) // R4
    else $error("point-to-point id word wrong");
  AST_KEY_WORD: assert property (go && tcb_r[7:6] != NPCC_PT_P2P |=>
      kq_r == $past(hwdata)) // R3
    else $error("key word not the written value");
  AST_ODD_PAR: assert property (pv_r && pf_r |-> npcc_odd(cq_r, kq_r, pq_r))
    // R7
    else $error("launched packet parity not odd");
  AST_PAY_FLAG: assert property (go |=> cq_r[NPCC_CB_PAY] == $past(tdw_r))
    // R20
    else $error("payload flag does not follow data write");
  AST_SEQ_CODE: assert property (go && tcb_r[7:6] == NPCC_PT_P2P |=>
      cq_r[5:4] == $past(hwdata[17:16])) // R12
    else $error("sequence code not from key write");
  AST_STAMP_ROUTE: assert property (go && tcb_r[7:6] != NPCC_PT_P2P |=>
      cq_r[5:2] == $past(tcb_r[5:2])) // R10
    else $error("stamp or route bits altered");
  AST_LAUNCH: assert property (go |=> st_r == NPCC_S_CTRL && pv_r && pf_r)
    // R21
    else $error("key write did not launch a packet");
  AST_ORDER: assert property (s_ctrl_beat |=> s_key_beat and (pw_r == kq_r))
    // R24
    else $error("key beat does not follow control beat");
  AST_LAST_BEAT: assert property (s_key_beat and pl_r |-> !cq_r[NPCC_CB_PAY])
    // R8
    else $error("short packet claims a payload");
  AST_UNBUF_WAIT: assert property (hsel && htrans[1] && hready && !busy_r
      && hwrite && haddr[31:28] == NPCC_BASE_UNBUF
      |=> !hready_r [*2] ##1 hready_r) // R19
    else $error("unbuffered write wait wrong");

endmodule // npcc_top
`default_nettype wire

// [test/npcc_router_model.sv]
// router model: takes launched beats and injects received packets
`default_nettype none
module npcc_router_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic stall,
  input wire logic slow,
  input wire logic pkt_valid,
  input wire logic [31:0] pkt_word,
  input wire logic pkt_first,
  input wire logic pkt_last,
  output logic pkt_ready,
  output logic rx_pkt_valid,
  output logic [7:0] rx_pkt_ctrl,
  output logic [31:0] rx_pkt_key,
  output logic [31:0] rx_pkt_data,
  output logic [2:0] rx_pkt_route,
  output logic rx_pkt_frame_err
);
  timeunit 1ns;
  timeprecision 1ns;
  // ********************************
  // transmit side
  // ********************************
  logic [33:0] beats[$]; // {first, last, word} in arrival order
  // ready low while stalled, every other cycle when slow
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pkt_ready <= 1'b0;
    end else begin
      pkt_ready <= !stall && !(slow && pkt_ready);
    end
  end
  // order kept as taken so the bench can judge beat order
  always @(posedge hclk) begin
    if (hresetn && pkt_valid && pkt_ready) begin
      beats.push_back({pkt_first, pkt_last, pkt_word});
    end
  end
  // ********************************
  // receive side
  // ********************************
  initial begin
    rx_pkt_valid = 1'b0;
    rx_pkt_ctrl = 8'h00;
    rx_pkt_key = 32'h0;
    rx_pkt_data = 32'h0;
    rx_pkt_route = 3'h0;
    rx_pkt_frame_err = 1'b0;
  end
  // one-cycle pulse; lines then show inverted values, not stale ones
  task automatic send(input logic [7:0] c, input logic [31:0] k,
                      input logic [31:0] d, input logic [2:0] r,
                      input logic fe);
    rx_pkt_valid <= 1'b1;
    rx_pkt_ctrl <= c;
    rx_pkt_key <= k;
    rx_pkt_data <= d;
    rx_pkt_route <= r;
    rx_pkt_frame_err <= fe;
    @(posedge hclk);
    rx_pkt_valid <= 1'b0;
    rx_pkt_ctrl <= ~c;
    rx_pkt_key <= ~k;
    rx_pkt_data <= ~d;
    rx_pkt_route <= ~r;
    rx_pkt_frame_err <= ~fe;
  endtask
endmodule // npcc_router_model
`default_nettype wire

// [test/npcc_top_test.sv]
// self-checking bench for the node packet comms controller
`default_nettype none
module npcc_top_test;
  import npcc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] BUF = 32'h2000_0000; // buffered base
  localparam logic [31:0] UNB = 32'h1000_0000; // unbuffered base
  localparam logic [15:0] SRC_ID = 16'h4B1D; // our chip id
  localparam logic [31:0] RK = 32'h6C0F_93A7;
  localparam logic [31:0] RD = 32'h0B5E_D214;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic stall, slow, pkt_valid, pkt_ready, pkt_first, pkt_last;
  logic rx_pkt_valid, rx_pkt_frame_err;
  logic [31:0] haddr, hwdata, hrdata, pkt_word, rx_pkt_key, rx_pkt_data;
  logic [31:0] rd_val;
  logic [1:0] htrans;
  logic [2:0] hsize, pkt_route, rx_pkt_route;
  logic [7:0] rx_pkt_ctrl, rb;
  int miscompares, n_compared, lat;
  assign hready = hreadyout; // single slave
  npcc_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .pkt_valid(pkt_valid),
    .pkt_ready(pkt_ready), .pkt_word(pkt_word), .pkt_first(pkt_first),
    .pkt_last(pkt_last), .pkt_route(pkt_route),
    .rx_pkt_valid(rx_pkt_valid), .rx_pkt_ctrl(rx_pkt_ctrl),
    .rx_pkt_key(rx_pkt_key), .rx_pkt_data(rx_pkt_data),
    .rx_pkt_route(rx_pkt_route), .rx_pkt_frame_err(rx_pkt_frame_err));
  npcc_router_model rtr_u (.hclk(hclk), .hresetn(hresetn), .stall(stall),
    .slow(slow), .pkt_valid(pkt_valid), .pkt_word(pkt_word),
    .pkt_first(pkt_first), .pkt_last(pkt_last), .pkt_ready(pkt_ready),
    .rx_pkt_valid(rx_pkt_valid), .rx_pkt_ctrl(rx_pkt_ctrl),
    .rx_pkt_key(rx_pkt_key), .rx_pkt_data(rx_pkt_data),
    .rx_pkt_route(rx_pkt_route), .rx_pkt_frame_err(rx_pkt_frame_err));
  // ********************************
  // helpers
  // ********************************
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  task automatic chk(input string nm, input logic [33:0] e,
                     input logic [33:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one single AHB transfer; entered just after a rising edge
  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] d);
    int n;
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    rd_val = hrdata;
    lat = n; // edges from take to completion
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e,
                        input string nm);
    xfer(1'b0, a, 32'h0);
    chk(nm, {2'b00, e}, {2'b00, rd_val});
  endtask
  // control byte as it must leave: payload flag, odd parity overall
  function automatic logic [7:0] mk_ctrl(input logic [7:0] c,
      input logic [31:0] kb, input logic [31:0] d, input logic pay);
    logic [7:0] b;
    b = c;
    b[1] = pay;
    b[0] = ~((^b[7:1]) ^ (^kb) ^ (pay & (^d)));
    return b;
  endfunction
  // launch one packet and compare every beat the router took
  task automatic send_chk(input logic [7:0] c, input logic [31:0] k,
                          input logic [31:0] d, input logic pay);
    logic [31:0] kb;
    logic [7:0] b;
    int n;
    kb = k;
    b = c;
    if (c[7:6] == NPCC_PT_P2P) begin
      kb = {SRC_ID, k[15:0]};
      b[5:4] = k[17:16];
    end
    b = mk_ctrl(b, kb, d, pay);
    xfer(1'b1, BUF | 32'h00, {8'h00, c, 16'h0000});
    if (pay) begin
      xfer(1'b1, BUF | 32'h04, d);
    end
    xfer(1'b1, BUF | 32'h08, k);
    n = 0;
    while (rtr_u.beats.size() < 2 + pay && n < 60) begin
      @(posedge hclk);
      n++;
    end
    repeat (4) @(posedge hclk);
    chk("beat count", 34'(2 + pay), 34'(rtr_u.beats.size()));
    chk("control beat", {2'b10, 24'h0, b}, rtr_u.beats[0]);
    chk("key beat", {1'b0, ~pay, kb}, rtr_u.beats[1]);
    if (pay) begin
      chk("payload beat", {2'b01, d}, rtr_u.beats[2]);
    end
    rtr_u.beats.delete();
  endtask
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ********************************
  // tests
  // ********************************
  // a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge hclk);
    miscompares++;
    give_verdict;
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    stall = 1'b0;
    slow = 1'b0;
    miscompares = 0;
    n_compared = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // reset values, unmapped and write-only places
    rd_chk(BUF | 32'h00, 32'h9000_0000, "tx_control reset");
    rd_chk(BUF | 32'h18, 32'h0700_0000, "route reset");
    rd_chk(BUF | 32'h0C, 32'h0, "rx_status reset");
    rd_chk(32'h3000_0018, 32'h0, "unmapped base");
    rd_chk(BUF | 32'h04, 32'h0, "tx_data_word read");
    // both bases reach the same word; unbuffered write is slower
    xfer(1'b1, BUF | 32'h1C, 32'hA5A5_3C3C);
    chk("buffered wait", 34'(NPCC_WAIT_BUF + 1), 34'(lat));
    xfer(1'b1, UNB | 32'h1C, 32'h5A5A_C3C3);
    chk("unbuffered wait", 34'(NPCC_WAIT_UNBUF + 1), 34'(lat));
    rd_chk(BUF | 32'h1C, 32'h5A5A_C3C3, "test_register");
    // route other than 111: stamp taken from tx_control
    xfer(1'b1, BUF | 32'h18, {5'h00, 3'h5, 8'h00, SRC_ID});
    repeat (2) @(posedge hclk);
    chk("pkt_route", 34'(3'h5), 34'(pkt_route));
    // every type; payload alternates so the data flag must clear
    for (int i = 0; i < 8; i++) begin
      slow <= i[2];
      send_chk({i[2:1], 6'h27}, 32'h8A5C_3E01 ^ i, 32'hC3A5_0F96 + i,
               i[0]);
    end
    // overrun: second key write while the router stalls is lost
    slow <= 1'b0;
    stall <= 1'b1;
    xfer(1'b1, BUF | 32'h00, 32'h0);
    xfer(1'b1, BUF | 32'h08, 32'h1111_0000);
    xfer(1'b1, BUF | 32'h08, 32'h2222_0000);
    xfer(1'b0, BUF | 32'h00, 32'h0);
    chk("tx flags stalled", 34'h6000_0000, {2'b00, rd_val & 32'hF000_0000});
    stall <= 1'b0;
    repeat (10) @(posedge hclk);
    chk("beats after overrun", 34'h2, 34'(rtr_u.beats.size()));
    chk("kept key", {2'b01, 32'h1111_0000}, rtr_u.beats[1]);
    rtr_u.beats.delete();
    xfer(1'b1, BUF | 32'h00, 32'h0);
    rd_chk(BUF | 32'h00, 32'h9000_0000, "tx flags cleared");
    // receive each type with payload, then key read clears R
    for (int t = 0; t < 4; t++) begin
      rb = mk_ctrl({t[1:0], 6'h04}, RK, RD, 1'b1);
      rtr_u.send(rb, RK, RD, 3'h3, 1'b0);
      xfer(1'b0, BUF | 32'h0C, 32'h0);
      chk("rx_status", {2'b00, 5'h12, 3'h3, rb, 16'h0}, {2'b00,
          rd_val & 32'hFFFF_FFF0});
      chk("rx type flag", 34'h1, {33'h0, rd_val[t]});
      rd_chk(BUF | 32'h10, RD, "rx_data_word");
      rd_chk(BUF | 32'h14, RK, "rx_key_word");
      xfer(1'b0, BUF | 32'h0C, 32'h0);
      chk("rx received cleared", 34'h0, {33'h0, rd_val[31]});
    end
    // parity and framing faults are sticky until written 0
    rtr_u.send(rb ^ 8'h01, RK, RD, 3'h3, 1'b1);
    xfer(1'b0, BUF | 32'h0C, 32'h0);
    chk("rx errors", 34'hE000_0000, {2'b00, rd_val & 32'hF000_0000});
    xfer(1'b1, BUF | 32'h0C, 32'h0);
    xfer(1'b0, BUF | 32'h0C, 32'h0);
    chk("rx errors cleared", 34'h0, {2'b00, rd_val & 32'h6000_0000});
    give_verdict;
  end
endmodule // npcc_top_test
`default_nettype wire
